// ### core/nti_translate.sv
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none

// ----------------------------------------------------------------
// Result buffer
// ----------------------------------------------------------------
// Depth must be a power of two: the pointers wrap naturally.
module nti_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Fill side
   input wire logic i_push_valid,
   output logic o_push_ready,
   input wire logic [WIDTH-1:0] i_push_data,
   // Drain side
   output logic o_pop_valid,
   input wire logic i_pop_ready,
   output logic [WIDTH-1:0] o_pop_data,
   output logic [$clog2(DEPTH):0] o_count
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] cnt;
   wire push_ok = i_push_valid && o_push_ready;
   wire pop_ok = o_pop_valid && i_pop_ready;

   assign o_push_ready = (cnt != (AW+1)'(DEPTH));
   assign o_pop_valid = (cnt != '0);
   assign o_pop_data = mem[rd_ptr];
   assign o_count = cnt;

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
      end
      else if (push_ok)
      begin
         mem[wr_ptr] <= i_push_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= '0;
      end
      else
      begin
         wr_ptr <= wr_ptr + AW'(push_ok);
         rd_ptr <= rd_ptr + AW'(pop_ok);
         cnt <= cnt + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
      end
   end
endmodule // nti_fifo

// Behaviour
// - One global 64-entry identifier mapping table.
// - Only valid entries take part in lookups.
// - Entry holds function 3:1, device 8:4.
// - Entry holds bus 16:9, partition 19:17.
// - Entry keeps bits 29, 30, 31 controls.
// - Requests match requester ID and own partition.
// - Request bus becomes destination endpoint bus.
// - Device bit 4 set, bit 3 cleared.
// - Entry index fills low device and function.
// - Completion lookup only when bits 7:6 are 10.
// - Completion index is requester ID bits 5:0.
// - Valid completion goes to entry's partition.
// - Completion requester ID restored from entry.
// - Completer ID becomes destination endpoint ID.
// - Memory address compared against windows 0 to 5.
// - Lookup window: entry 0-11 gives partition, base.
// - Outgoing address is base plus window offset, or base plus slot offset in a lookup window.
// - Window 0 hits access local registers.
module nti_translate (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Register port
   input wire logic [nti_pkg::RA_W-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Inbound packet header
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire nti_pkg::nti_kind_t i_in_kind,
   input wire logic [31:0] i_in_addr,
   input wire logic [15:0] i_in_reqid,
   input wire logic [15:0] i_in_cplid,
   // Translated packet header
   output logic o_out_valid,
   input wire logic i_out_ready,
   output var nti_pkg::nti_kind_t o_out_kind,
   output var nti_pkg::nti_act_t o_out_act,
   output logic [2:0] o_out_part,
   output logic [31:0] o_out_addr,
   output logic [15:0] o_out_reqid,
   output logic [15:0] o_out_cplid
);
   import nti_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] reg_slot(input logic [RA_W-1:0] a,
                                           input logic [RA_W-1:0] base,
                                           input int unsigned n);
      logic [RA_W-1:0] d;
      d = a - base;
      reg_slot = 7'h00;
      if (a >= base && d[1:0] == 2'h0 && 32'(d[RA_W-1:2]) < n)
         reg_slot = {1'b1, d[7:2]};
   endfunction

   function automatic logic [31:0] win_mask(input logic [5:0] size);
      win_mask = 32'hFFFF_FFFF << size;
   endfunction

   function automatic logic [15:0] map_bdf(input logic [31:0] ent);
      map_bdf = ent[MAP_BUS_MSB:MAP_INITIATOR_FUNCTION_LSB];
   endfunction

   function automatic logic [2:0] map_part(input logic [31:0] ent);
      map_part = ent[MAP_PART_MSB:MAP_PART_LSB];
   endfunction

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [31:0] map_tbl [MAP_NUM];
   logic [31:0] bar_base [BAR_NUM];
   logic [31:0] bar_setup [BAR_NUM];
   logic [31:0] bar_xlat [BAR_NUM];
   logic [31:0] lut_tbl [LUT_NUM];
   logic [15:0] ep_bdf [PART_NUM];
   logic [2:0] own_part;
   logic [7:0] miss_cnt;
   logic [FIFO_CNT_W-1:0] fifo_cnt;
   logic [31:0] rd_word;

   wire [6:0] map_sel = reg_slot(i_reg_addr, REG_MAP, MAP_NUM);
   wire [6:0] base_sel = reg_slot(i_reg_addr, REG_BAR_BASE, BAR_NUM);
   wire [6:0] setup_sel = reg_slot(i_reg_addr, REG_BAR_SETUP, BAR_NUM);
   wire [6:0] xlat_sel = reg_slot(i_reg_addr, REG_BAR_XLAT, BAR_NUM);
   wire [6:0] lut_sel = reg_slot(i_reg_addr, REG_LUT, LUT_NUM);
   wire [6:0] ep_sel = reg_slot(i_reg_addr, REG_EP_BDF, PART_NUM);
   wire own_sel = (i_reg_addr == REG_OWN_PART);
   wire stat_sel = (i_reg_addr == REG_STATUS);

   // Reserved entry bits 28:20 are dropped on write so they read as zero.
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         for (int i = 0; i < MAP_NUM; i++) map_tbl[i] <= MAP_RESET;
         for (int i = 0; i < BAR_NUM; i++)
         begin
            bar_base[i] <= WIN_RESET;
            bar_setup[i] <= WIN_RESET;
            bar_xlat[i] <= WIN_RESET;
         end
         for (int i = 0; i < LUT_NUM; i++) lut_tbl[i] <= WIN_RESET;
         for (int i = 0; i < PART_NUM; i++) ep_bdf[i] <= BDF_RESET;
         own_part <= PART_RESET;
      end
      else if (i_reg_wr)
      begin
         if (map_sel[6]) map_tbl[map_sel[5:0]] <= i_reg_wdata & MAP_WR_MASK;
         if (base_sel[6]) bar_base[base_sel[2:0]] <= i_reg_wdata;
         if (setup_sel[6]) bar_setup[setup_sel[2:0]] <= i_reg_wdata & SETUP_WR_MASK;
         if (xlat_sel[6]) bar_xlat[xlat_sel[2:0]] <= i_reg_wdata;
         if (lut_sel[6]) lut_tbl[lut_sel[3:0]] <= i_reg_wdata & LUT_WR_MASK;
         if (ep_sel[6]) ep_bdf[ep_sel[2:0]] <= i_reg_wdata[15:0];
         if (own_sel) own_part <= i_reg_wdata[2:0];
      end
   end

   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (map_sel[6]) rd_word = map_tbl[map_sel[5:0]];
      if (base_sel[6]) rd_word = bar_base[base_sel[2:0]];
      if (setup_sel[6]) rd_word = bar_setup[setup_sel[2:0]];
      if (xlat_sel[6]) rd_word = bar_xlat[xlat_sel[2:0]];
      if (lut_sel[6]) rd_word = lut_tbl[lut_sel[3:0]];
      if (ep_sel[6]) rd_word = {16'h0000, ep_bdf[ep_sel[2:0]]};
      if (own_sel) rd_word = {29'h0000_0000, own_part};
      if (stat_sel) rd_word = {16'h0000, miss_cnt, 4'h0, fifo_cnt};
   end

   // Read data appear only in the cycle after the strobe.
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst) o_reg_rdata <= 32'h0000_0000;
      else o_reg_rdata <= i_reg_rd ? rd_word : 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Requester identifier lookup
   // ----------------------------------------------------------------
   logic [MAP_NUM-1:0] map_hit;
   logic map_found;
   logic [5:0] map_idx;

   for (genvar g = 0; g < MAP_NUM; g++)
   begin : g_map
      assign map_hit[g] = map_tbl[g][MAP_VALID_BIT]
                          && map_part(map_tbl[g]) == own_part
                          && map_bdf(map_tbl[g]) == i_in_reqid;
   end

   // The lowest matching entry wins if software loads duplicates.
   always_comb
   begin
      map_found = 1'b0;
      map_idx = 6'h00;
      for (int i = MAP_NUM - 1; i >= 0; i--)
      begin
         if (map_hit[i])
         begin
            map_found = 1'b1;
            map_idx = 6'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Window match and address translation
   // ----------------------------------------------------------------
   logic [BAR_NUM-1:0] bar_hit;
   logic bar_found;
   logic [2:0] bar_idx;

   for (genvar g = 0; g < BAR_NUM; g++)
   begin : g_bar
      assign bar_hit[g] = (bar_setup[g][SETUP_SIZE_MSB:0] != 6'h00)
                          && ((i_in_addr ^ bar_base[g])
                              & win_mask(bar_setup[g][SETUP_SIZE_MSB:0])) == 32'h0;
   end

   always_comb
   begin
      bar_found = 1'b0;
      bar_idx = 3'h0;
      for (int i = BAR_NUM - 1; i >= 0; i--)
      begin
         if (bar_hit[i])
         begin
            bar_found = 1'b1;
            bar_idx = 3'(i);
         end
      end
   end

   // A lookup window is cut into sixteen slots; slots 12 to 15 never hit.
   wire [31:0] sel_setup = bar_setup[bar_idx];
   wire [5:0] sel_size = sel_setup[SETUP_SIZE_MSB:0];
   wire sel_lut = sel_setup[SETUP_LUT_BIT];
   wire [31:0] win_off = i_in_addr & ~win_mask(sel_size);
   wire [5:0] slot_shift = sel_size - LUT_SLOT_BITS;
   wire [3:0] lut_slot = 4'(win_off >> slot_shift);
   wire [31:0] sub_off = win_off & ~(32'hFFFF_FFFF << slot_shift);
   wire lut_ok = (sel_size >= LUT_MIN_SIZE) && (32'(lut_slot) < LUT_NUM);
   wire [31:0] lut_ent = lut_ok ? lut_tbl[lut_slot] : 32'h0000_0000;
   wire [2:0] mem_part = sel_lut ? lut_ent[LUT_PART_MSB:LUT_PART_LSB]
                                 : sel_setup[SETUP_PART_MSB:SETUP_PART_LSB];
   wire [31:0] mem_addr = sel_lut ? (lut_ent & LUT_BASE_MASK) + sub_off
                                  : bar_xlat[bar_idx] + win_off;
   wire mem_ok = bar_found && (!sel_lut || lut_ent[LUT_VALID_BIT]);
   wire [15:0] xlat_rid = {ep_bdf[mem_part][15:8], 1'b1, 1'b0, map_idx};

   // ----------------------------------------------------------------
   // Completion identifier lookup
   // ----------------------------------------------------------------
   wire cpl_in_range = (i_in_reqid[7:6] == RID_RANGE);
   wire [31:0] cpl_ent = map_tbl[i_in_reqid[5:0]];
   wire [2:0] cpl_part = map_part(cpl_ent);

   // ----------------------------------------------------------------
   // Result selection
   // ----------------------------------------------------------------
   nti_act_t push_act;
   logic [2:0] push_part;
   logic [31:0] push_addr;
   logic [15:0] push_rid;
   logic [15:0] push_cid;
   logic push_ready;
   logic [RES_W-1:0] pop_data;
   wire push = i_in_valid && push_ready;

   always_comb
   begin
      push_act = NTI_ACT_PASS;
      push_part = own_part;
      push_addr = i_in_addr;
      push_rid = i_in_reqid;
      push_cid = i_in_cplid;
      case (i_in_kind)
         NTI_KIND_MEM:
         begin
            push_act = NTI_ACT_MISS;
            if (bar_found && bar_idx == 3'h0)
               push_act = NTI_ACT_LOCAL;
            else if (mem_ok && map_found)
            begin
               push_act = NTI_ACT_FWD;
               push_part = mem_part;
               push_addr = mem_addr;
               push_rid = xlat_rid;
            end
         end
         NTI_KIND_CPL:
         begin
            if (cpl_in_range)
            begin
               push_act = NTI_ACT_MISS;
               if (cpl_ent[MAP_VALID_BIT])
               begin
                  push_act = NTI_ACT_FWD;
                  push_part = cpl_part;
                  push_rid = map_bdf(cpl_ent);
                  push_cid = ep_bdf[cpl_part];
               end
            end
         end
         default: push_act = NTI_ACT_PASS;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst) miss_cnt <= 8'h00;
      else if (push && push_act == NTI_ACT_MISS) miss_cnt <= miss_cnt + 8'h01;
   end

   // ----------------------------------------------------------------
   // Output buffer
   // ----------------------------------------------------------------
   // A stalled consumer holds off the inbound side through o_in_ready.
   assign o_in_ready = push_ready;

   nti_fifo #(
      .WIDTH(RES_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_push_valid(i_in_valid),
      .o_push_ready(push_ready),
      .i_push_data({i_in_kind, push_act, push_part, push_addr, push_rid, push_cid}),
      .o_pop_valid(o_out_valid),
      .i_pop_ready(i_out_ready),
      .o_pop_data(pop_data),
      .o_count(fifo_cnt)
   );

   assign o_out_kind = nti_kind_t'(pop_data[70:69]);
   assign o_out_act = nti_act_t'(pop_data[68:67]);
   assign o_out_part = pop_data[66:64];
   assign o_out_addr = pop_data[63:32];
   assign o_out_reqid = pop_data[31:16];
   assign o_out_cplid = pop_data[15:0];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   sequence s_mem_fwd;
      push && i_in_kind == NTI_KIND_MEM && push_act == NTI_ACT_FWD;
   endsequence

   sequence s_cpl_fwd;
      push && i_in_kind == NTI_KIND_CPL && push_act == NTI_ACT_FWD;
   endsequence

   chk_req_rid_index: assert property (s_mem_fwd |-> push_rid[7:6] == 2'h2
      && map_tbl[push_rid[5:0]][MAP_VALID_BIT] && map_bdf(map_tbl[push_rid[5:0]]) == i_in_reqid
      && map_part(map_tbl[push_rid[5:0]]) == own_part)
      else $error("Request ID not built from a matching entry.");

   chk_req_rid_bus: assert property (s_mem_fwd |-> push_rid[15:8] == ep_bdf[push_part][15:8])
      else $error("Request bus is not the destination endpoint bus.");

   chk_cpl_range: assert property (push && i_in_kind == NTI_KIND_CPL
      && i_in_reqid[7:6] != 2'h2 |-> push_act == NTI_ACT_PASS && push_rid == i_in_reqid)
      else $error("Completion outside range was looked up.");

   chk_cpl_rid: assert property (s_cpl_fwd |-> map_tbl[i_in_reqid[5:0]][MAP_VALID_BIT]
      && push_rid == map_bdf(map_tbl[i_in_reqid[5:0]]))
      else $error("Completion requester ID not restored.");

   chk_cpl_dest: assert property (s_cpl_fwd |-> push_part == map_part(map_tbl[i_in_reqid[5:0]])
      && push_cid == ep_bdf[push_part])
      else $error("Completion partition or completer ID wrong.");

   chk_bar0_local: assert property (push && i_in_kind == NTI_KIND_MEM && bar_hit[0]
      |-> push_act == NTI_ACT_LOCAL)
      else $error("Window 0 access was not kept local.");

   chk_direct_addr: assert property (s_mem_fwd and !sel_lut
      |-> push_addr - bar_xlat[bar_idx] == (i_in_addr & ~win_mask(sel_size)))
      else $error("Direct window address wrong.");

   chk_lut_entry: assert property (s_mem_fwd and sel_lut |-> lut_slot < 4'hC
      && lut_tbl[lut_slot][LUT_VALID_BIT] && push_part == lut_tbl[lut_slot][3:1])
      else $error("Lookup window used an absent entry.");

   chk_fifo_head: assert property (push && fifo_cnt == 4'h0
      |=> o_out_valid && o_out_reqid == $past(push_rid) && o_out_act == $past(push_act))
      else $error("Buffer head does not show the pushed result.");

   chk_reg_read: assert property (i_reg_rd && own_sel
      |=> o_reg_rdata == {29'h0000_0000, own_part} ##1 o_reg_rdata == 32'h0 || $past(i_reg_rd))
      else $error("Register read data wrong or held too long.");

endmodule // nti_translate

`default_nettype wire

// ### core/nti_pkg.sv
`default_nettype none

package nti_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned MAP_NUM = 64;
   localparam int unsigned BAR_NUM = 6;
   localparam int unsigned LUT_NUM = 12;
   localparam int unsigned PART_NUM = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_CNT_W = 4;
   localparam int unsigned RES_W = 71;
   localparam int unsigned RA_W = 10;

   // ----------------------------------------------------------------
   // Identifier mapping entry fields
   // ----------------------------------------------------------------
   localparam int unsigned MAP_VALID_BIT = 0;
   localparam int unsigned MAP_INITIATOR_FUNCTION_LSB = 1;
   localparam int unsigned MAP_DEV_MSB = 8;
   localparam int unsigned MAP_BUS_MSB = 16;
   localparam int unsigned MAP_PART_LSB = 17;
   localparam int unsigned MAP_PART_MSB = 19;
   localparam int unsigned MAP_ATP_BIT = 29;
   localparam int unsigned MAP_CNS_BIT = 30;
   localparam int unsigned MAP_RNS_BIT = 31;
   localparam logic [31:0] MAP_WR_MASK = 32'hE00F_FFFF;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Requester identifier layout
   // ----------------------------------------------------------------
   localparam logic [1:0] RID_RANGE = 2'h2;

   // ----------------------------------------------------------------
   // Window setup and lookup entry fields
   // ----------------------------------------------------------------
   localparam int unsigned SETUP_SIZE_MSB = 5;
   localparam int unsigned SETUP_LUT_BIT = 8;
   localparam int unsigned SETUP_PART_LSB = 16;
   localparam int unsigned SETUP_PART_MSB = 18;
   localparam logic [31:0] SETUP_WR_MASK = 32'h0007_013F;
   localparam logic [5:0] LUT_SLOT_BITS = 6'h04;
   localparam logic [5:0] LUT_MIN_SIZE = 6'h10;
   localparam int unsigned LUT_VALID_BIT = 0;
   localparam int unsigned LUT_PART_LSB = 1;
   localparam int unsigned LUT_PART_MSB = 3;
   localparam logic [31:0] LUT_WR_MASK = 32'hFFFF_F00F;
   localparam logic [31:0] LUT_BASE_MASK = 32'hFFFF_F000;
   localparam logic [31:0] WIN_RESET = 32'h0000_0000;
   localparam logic [15:0] BDF_RESET = 16'h0000;
   localparam logic [2:0] PART_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [RA_W-1:0] REG_MAP = 10'h000;
   localparam logic [RA_W-1:0] REG_BAR_BASE = 10'h100;
   localparam logic [RA_W-1:0] REG_BAR_SETUP = 10'h120;
   localparam logic [RA_W-1:0] REG_BAR_XLAT = 10'h140;
   localparam logic [RA_W-1:0] REG_LUT = 10'h180;
   localparam logic [RA_W-1:0] REG_OWN_PART = 10'h1C0;
   localparam logic [RA_W-1:0] REG_EP_BDF = 10'h1E0;
   localparam logic [RA_W-1:0] REG_STATUS = 10'h200;

   // ----------------------------------------------------------------
   // Packet kinds and outcomes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {NTI_KIND_MEM, NTI_KIND_CPL, NTI_KIND_OTHER} nti_kind_t;
   typedef enum logic [1:0] {NTI_ACT_FWD, NTI_ACT_LOCAL, NTI_ACT_MISS, NTI_ACT_PASS} nti_act_t;

endpackage

`default_nettype wire

// ### dv/nti_sink.sv
`default_nettype none

// ----------------------------------------------------------------
// Consumer of translated headers
// ----------------------------------------------------------------
// Collects every accepted result so the bench can compare in order.
module nti_sink (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Flow control from the bench
   input wire logic i_stall,
   // Result stream
   input wire logic i_out_valid,
   output logic o_out_ready,
   input wire logic [nti_pkg::RES_W-1:0] i_res
);
   import nti_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic [RES_W-1:0] got_q[$];

   assign o_out_ready = !i_stall;

   always @(posedge i_mclk)
   begin
      if (i_nrst && i_out_valid && o_out_ready)
      begin
         got_q.push_back(i_res);
      end
   end
endmodule // nti_sink

`default_nettype wire

// ### dv/nti_translate_tb.sv
`default_nettype none

`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module nti_translate_tb;
   import nti_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_in_valid, i_out_ready, o_in_ready, o_out_valid;
   logic [RA_W-1:0] i_reg_addr;
   logic [31:0] i_reg_wdata, o_reg_rdata, i_in_addr, o_out_addr;
   nti_kind_t i_in_kind, o_out_kind;
   nti_act_t o_out_act;
   logic [2:0] o_out_part;
   logic [15:0] i_in_reqid, i_in_cplid, o_out_reqid, o_out_cplid;
   logic [RES_W-1:0] res;
   logic stall;
   int errors = 0;
   int comparisons = 0;
   logic [RES_W-1:0] exp_q[$];
   logic [RES_W-1:0] msk_q[$];
   localparam nti_act_t af = NTI_ACT_FWD;
   localparam nti_act_t am = NTI_ACT_MISS;
   localparam nti_act_t ap = NTI_ACT_PASS;
   localparam logic [9:0] wa [14] = '{10'h000, 10'h008, 10'h024, 10'h1E0, 10'h1E4, 10'h1E8,
      10'h120, 10'h104, 10'h124, 10'h144, 10'h108, 10'h128, 10'h180, 10'h184};
   localparam logic [31:0] wd [14] = '{32'h11, 32'h20, 32'h31, 32'h101, 32'h100, 32'h200,
      32'hC, 32'hE1000000, 32'h14, 32'h10000000, 32'hE0000000, 32'h118, 32'h11000003,
      32'h18000005};

   assign res = {o_out_kind, o_out_act, o_out_part, o_out_addr, o_out_reqid, o_out_cplid};

   nti_translate uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
      .i_in_kind(i_in_kind), .i_in_addr(i_in_addr), .i_in_reqid(i_in_reqid),
      .i_in_cplid(i_in_cplid), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
      .o_out_kind(o_out_kind), .o_out_act(o_out_act), .o_out_part(o_out_part),
      .o_out_addr(o_out_addr), .o_out_reqid(o_out_reqid), .o_out_cplid(o_out_cplid));

   nti_sink sink (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_stall(stall),
      .i_out_valid(o_out_valid), .o_out_ready(i_out_ready), .i_res(res));

   always #12.5 i_mclk = ~i_mclk;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      if (errors == 0 && comparisons > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      @(negedge i_mclk);
      `CHK(o_reg_rdata, e)
   endtask

   // Identifier fields of a miss are undefined, so they are masked out.
   task automatic send(input nti_kind_t k, input logic [31:0] a, input logic [15:0] r, c,
      input nti_act_t act, input logic [2:0] p, input logic [31:0] ea, input logic [15:0] er, ec);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_in_valid <= 1'b1;
      i_in_kind <= k;
      i_in_addr <= a;
      i_in_reqid <= r;
      i_in_cplid <= c;
      exp_q.push_back({k, act, p, ea, er, ec});
      msk_q.push_back((act == af || act == ap) ? '1 : {{39{1'b1}}, 32'h0});
      do
      begin
         @(negedge i_mclk);
         n++;
         if (n > 50)
         begin
            errors++;
            finish_test();
         end
      end while (o_in_ready !== 1'b1);
      @(posedge i_mclk);
      i_in_valid <= 1'b0;
   endtask

   task automatic mem(input logic [31:0] a, input logic [15:0] r, input nti_act_t act,
      input logic [2:0] p, input logic [31:0] ea, input logic [15:0] er);
      send(NTI_KIND_MEM, a, r, 16'h0000, act, p, ea, er, 16'h0000);
   endtask

   task automatic cpl(input logic [15:0] r, c, input nti_act_t act, input logic [2:0] p,
      input logic [15:0] er, ec);
      send(NTI_KIND_CPL, 32'h0, r, c, act, p, 32'h0, er, ec);
   endtask

   task automatic drain();
      int n;
      logic [RES_W-1:0] g, e, m;
      while (exp_q.size() > 0)
      begin
         n = 0;
         while (sink.got_q.size() == 0)
         begin
            @(negedge i_mclk);
            n++;
            if (n > 50)
            begin
               errors++;
               finish_test();
            end
         end
         g = sink.got_q.pop_front();
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK(g & m, e & m)
      end
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      {i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_in_valid, stall} = '0;
      {i_reg_addr, i_reg_wdata, i_in_addr, i_in_reqid, i_in_cplid} = '0;
      i_in_kind = NTI_KIND_MEM;
      repeat (16) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd(10'h000, 32'h0);
      rd(10'h3FC, 32'h0);
      rd(10'h002, 32'h0);
      wr(10'h0FC, 32'hFFFFFFFF);
      rd(10'h0FC, 32'hE00FFFFF);
      for (int i = 0; i < 14; i++) wr(wa[i], wd[i]);
      mem(32'hE0000123, 16'h0008, af, 3'h1, 32'h11000123, 16'h0180);
      mem(32'hE0100456, 16'h0018, af, 3'h2, 32'h18000456, 16'h0289);
      mem(32'hE0C00000, 16'h0008, am, 3'h0, 32'hE0C00000, 16'h0);
      mem(32'h00000010, 16'h0008, NTI_ACT_LOCAL, 3'h0, 32'h10, 16'h0);
      mem(32'hE1000020, 16'h0008, af, 3'h0, 32'h10000020, 16'h0180);
      mem(32'hE0000000, 16'h0009, am, 3'h0, 32'hE0000000, 16'h0);
      mem(32'hE0000000, 16'h0010, am, 3'h0, 32'hE0000000, 16'h0);
      mem(32'hE0000000, 16'hFFFF, am, 3'h0, 32'hE0000000, 16'h0);
      drain();
      cpl(16'h0180, 16'h0100, af, 3'h0, 16'h0008, 16'h0101);
      cpl(16'h0289, 16'h0200, af, 3'h0, 16'h0018, 16'h0101);
      cpl(16'h01BF, 16'h0200, af, 3'h7, 16'hFFFF, 16'h0000);
      cpl(16'h0140, 16'h0100, ap, 3'h0, 16'h0140, 16'h0100);
      cpl(16'h0182, 16'h0100, am, 3'h0, 16'h0, 16'h0);
      drain();
      // Hold the consumer off so the buffer fills and refuses.
      stall <= 1'b1;
      repeat (8) send(NTI_KIND_OTHER, 32'h5, 16'h1234, 16'h4321, ap, 3'h0, 32'h5, 16'h1234,
         16'h4321);
      @(negedge i_mclk);
      `CHK(o_in_ready, 1'b0)
      rd(10'h200, 32'h0508);
      @(posedge i_mclk);
      stall <= 1'b0;
      drain();
      rd(10'h200, 32'h0500);
      finish_test();
   end
endmodule // nti_translate_tb

`default_nettype wire
